// [src/atrb_pkg.sv]
/*
  Package of the analog trim register bank: register offsets, field
  positions, reset values and overcurrent filter delays.
  Assumes a byte-wide register port decoded from the internal SPI link.
*/
package atrb_pkg;
  localparam logic [7:0] TEST_OFS      = 8'h0e;
  localparam logic [7:0] TRIM1_OFS     = 8'h0f;
  localparam logic [7:0] TRIM2_OFS     = 8'h10;
  localparam logic [7:0] TRIM3_OFS     = 8'h11;
  localparam int         DLY_LSB       = 6;
  localparam int         REF_LSB       = 0;
  localparam int         HI2_LSB       = 6;
  localparam int         MID3_LSB      = 3;
  localparam int         LOW3_LSB      = 0;
  localparam logic [1:0] DLY_RST       = 2'h0;
  localparam logic [3:0] REF_RST       = 4'h0;
  localparam logic [7:0] TRIM_RST      = 8'h00;
  localparam logic [7:0] TEST_RST      = 8'h00;
  localparam int         CLK_MHZ       = 100;
  localparam int         DLY0_US       = 950;
  localparam int         DLY1_US       = 536;
  localparam int         DLY2_US       = 234;
  localparam int         DLY3_US       = 78;
  localparam int         DLY0_CYC      = DLY0_US * CLK_MHZ;
  localparam int         DLY1_CYC      = DLY1_US * CLK_MHZ;
  localparam int         DLY2_CYC      = DLY2_US * CLK_MHZ;
  localparam int         DLY3_CYC      = DLY3_US * CLK_MHZ;
  localparam logic [2:0] CODE3_RSVD    = 3'h4;
  localparam logic [3:0] REF_MAX_CODE  = 4'h8;
endpackage

// [src/atrb_bank.sv]
/*
  Trim and test register bank of the analog die, with the overcurrent
  filter timer and trim selection on the current-sense select bit.
  Assumes register strobes are one-cycle pulses already decoded from the
  internal SPI link, synchronous to i_sys_clk.
*/
// Overview of operation
// - Delay select sets overcurrent filter time
// - Reset clears delay select, longest delay
// - Reference trim write-only, cleared on reset
// - Trim2 bits 7:6 bridge12 trim, sense 0
// - Trim2 bits 5:3 bridge34 trim, sense 1
// - Trim2 bits 2:0 bridge12 trim, sense 1
// - Trim3 bits 7:6 bridge34 trim, sense 0
// - Trim3 bits 5:3 high-side 2/3 trim
// - Trim3 bits 2:0 high-side 1 trim
// - Trim2/3 read zero, reset clears them
// - Two-bit trims on sense 0, three-bit on 1
`timescale 1ns/10ps
`default_nettype none
module atrb_bank (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_current_sense_select,
  input  wire logic       i_overcurrent_raw,
  output logic      [7:0] o_rdata,
  output logic            o_rvalid,
  output logic      [3:0] o_reference_current_trim,
  output logic      [2:0] o_bridge12_trim,
  output logic      [2:0] o_bridge34_trim,
  output logic            o_bridge_trim_wide,
  output logic      [2:0] o_highside23_trim,
  output logic      [2:0] o_highside1_trim,
  output logic            o_overcurrent_shutdown
);

  typedef struct packed {
    logic [7:0]  test;
    logic [1:0]  dly;
    logic [3:0]  ref_trim;
    logic [7:0]  trim2;
    logic [7:0]  trim3;
    logic [16:0] oc_cnt;
    logic        oc_trip;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [3:0]  ref_out;
    logic [2:0]  b12_out;
    logic [2:0]  b34_out;
    logic        wide_out;
    logic [2:0]  hs23_out;
    logic [2:0]  hs1_out;
  } atrb_state_type;

  atrb_state_type st_q;
  atrb_state_type st_d;

  // Reserved code maps to no adjustment
  function automatic logic [2:0] atrb_clean3(input logic [2:0] code);
    return (code == atrb_pkg::CODE3_RSVD) ? 3'h0 : code;
  endfunction

  function automatic logic [16:0] atrb_delay(input logic [1:0] sel);
    case (sel)
      2'h0:    return 17'(atrb_pkg::DLY0_CYC);
      2'h1:    return 17'(atrb_pkg::DLY1_CYC);
      2'h2:    return 17'(atrb_pkg::DLY2_CYC);
      default: return 17'(atrb_pkg::DLY3_CYC);
    endcase
  endfunction

  always_comb begin
    st_d        = st_q;
    st_d.rvalid = i_rd;
    if (i_wr) begin
      case (i_addr)
        // Test register stores only; software is trusted never to write it
        atrb_pkg::TEST_OFS:  st_d.test = i_wdata;
        atrb_pkg::TRIM1_OFS: begin
          st_d.dly      = i_wdata[atrb_pkg::DLY_LSB +: 2];
          st_d.ref_trim = i_wdata[atrb_pkg::REF_LSB +: 4];
        end
        atrb_pkg::TRIM2_OFS: st_d.trim2 = i_wdata;
        atrb_pkg::TRIM3_OFS: st_d.trim3 = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        atrb_pkg::TEST_OFS:  st_d.rdata = st_q.test;
        // Reference trim is write-only, reads as zero
        atrb_pkg::TRIM1_OFS: st_d.rdata = {st_q.dly, 6'h00};
        default:             st_d.rdata = 8'h00;
      endcase
    end
    // Filter: shutdown only after the fault persists the selected time
    if (!i_overcurrent_raw) begin
      st_d.oc_cnt  = 17'h0;
      st_d.oc_trip = 1'b0;
    end else if (st_q.oc_cnt >= atrb_delay(st_q.dly) - 17'h1) begin
      st_d.oc_trip = 1'b1;
    end else begin
      st_d.oc_cnt = st_q.oc_cnt + 17'h1;
    end
    st_d.ref_out = (st_q.ref_trim > atrb_pkg::REF_MAX_CODE) ? 4'h0 : st_q.ref_trim;
    st_d.wide_out = i_current_sense_select;
    if (i_current_sense_select) begin
      st_d.b12_out = atrb_clean3(st_q.trim2[atrb_pkg::LOW3_LSB +: 3]);
      st_d.b34_out = atrb_clean3(st_q.trim2[atrb_pkg::MID3_LSB +: 3]);
    end else begin
      st_d.b12_out = {1'b0, st_q.trim2[atrb_pkg::HI2_LSB +: 2]};
      st_d.b34_out = {1'b0, st_q.trim3[atrb_pkg::HI2_LSB +: 2]};
    end
    st_d.hs23_out = atrb_clean3(st_q.trim3[atrb_pkg::MID3_LSB +: 3]);
    st_d.hs1_out  = atrb_clean3(st_q.trim3[atrb_pkg::LOW3_LSB +: 3]);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q          <= '0;
      st_q.test     <= atrb_pkg::TEST_RST;
      st_q.dly      <= atrb_pkg::DLY_RST;
      st_q.ref_trim <= atrb_pkg::REF_RST;
      st_q.trim2    <= atrb_pkg::TRIM_RST;
      st_q.trim3    <= atrb_pkg::TRIM_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata                  = st_q.rdata;
  assign o_rvalid                 = st_q.rvalid;
  assign o_reference_current_trim = st_q.ref_out;
  assign o_bridge12_trim          = st_q.b12_out;
  assign o_bridge34_trim          = st_q.b34_out;
  assign o_bridge_trim_wide       = st_q.wide_out;
  assign o_highside23_trim        = st_q.hs23_out;
  assign o_highside1_trim         = st_q.hs1_out;
  assign o_overcurrent_shutdown   = st_q.oc_trip;

  trim_read_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rd && (i_addr == atrb_pkg::TRIM2_OFS || i_addr == atrb_pkg::TRIM3_OFS)
    |=> o_rvalid && o_rdata == 8'h00)
    else $error("trim register read not zero");

  ref_write_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rd && i_addr == atrb_pkg::TRIM1_OFS |=> o_rdata[3:0] == 4'h0)
    else $error("reference trim visible on read");

  dly_reset_a: assert property (@(posedge i_sys_clk)
    !i_rst_n |=> st_q.dly == 2'h0 && st_q.trim2 == 8'h00)
    else $error("delay select not cleared by reset");

  sense_sel_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_current_sense_select |=> !o_bridge12_trim[2] && !o_bridge34_trim[2])
    else $error("two-bit trim wider than two bits");

  rsvd_code_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_highside1_trim != 3'h4 && o_highside23_trim != 3'h4)
    else $error("reserved code passed to output");

  ref_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_reference_current_trim <= 4'h8)
    else $error("undefined reference code passed");

  oc_fast_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q.dly == 2'h3 && !i_overcurrent_raw && !i_wr ##1 i_overcurrent_raw [*8]
    |-> !o_overcurrent_shutdown)
    else $error("overcurrent tripped before filter time");

  oc_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_overcurrent_raw |=> !o_overcurrent_shutdown)
    else $error("shutdown held without fault");

  dly_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_wr && i_addr == atrb_pkg::TRIM1_OFS |=> st_q.dly == $past(i_wdata[7:6]))
    else $error("delay select not written");

  bridge12_wide_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_current_sense_select && st_q.trim2[2:0] != 3'h4 |=> o_bridge12_trim == $past(st_q.trim2[2:0]))
    else $error("bridge 1/2 three-bit trim not applied");

  bridge34_wide_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_current_sense_select && st_q.trim2[5:3] != 3'h4 |=> o_bridge34_trim == $past(st_q.trim2[5:3]))
    else $error("bridge 3/4 three-bit trim not applied");

  bridge12_narrow_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_current_sense_select |=> o_bridge12_trim == {1'b0, $past(st_q.trim2[7:6])})
    else $error("bridge 1/2 two-bit trim not applied");

  bridge34_narrow_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_current_sense_select |=> o_bridge34_trim == {1'b0, $past(st_q.trim3[7:6])})
    else $error("bridge 3/4 two-bit trim not applied");

  hs23_pass_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q.trim3[5:3] != 3'h4 |=> o_highside23_trim == $past(st_q.trim3[5:3]))
    else $error("high-side 2/3 trim not applied");

  hs1_pass_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q.trim3[2:0] != 3'h4 |=> o_highside1_trim == $past(st_q.trim3[2:0]))
    else $error("high-side 1 trim not applied");

  wide_rsvd_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_current_sense_select |=> o_bridge12_trim != 3'h4 && o_bridge34_trim != 3'h4)
    else $error("reserved bridge code passed to output");

  ref_pass_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q.ref_trim <= 4'h8 |=> o_reference_current_trim == $past(st_q.ref_trim))
    else $error("reference trim not applied");

  ref_reset_a: assert property (@(posedge i_sys_clk)
    !i_rst_n |=> st_q.ref_trim == 4'h0 && st_q.trim3 == 8'h00)
    else $error("reference or high-side trim not cleared by reset");

  // Fastest setting must trip on the last counted cycle, not later
  oc_trip_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_overcurrent_raw && st_q.dly == 2'h3 && st_q.oc_cnt == 17'(atrb_pkg::DLY3_CYC - 1)
    |=> o_overcurrent_shutdown)
    else $error("overcurrent not tripped at filter time");

endmodule
`default_nettype wire

// [tb/atrb_mcu_model.sv]
/* Embedded microcontroller model: software side of the trim register port.
   Assumes the bank takes strobes on the rising edge of i_sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module atrb_mcu_model #(
  parameter logic [7:0] FLASH_TRIM1 = 8'h47,
  parameter logic [7:0] FLASH_TRIM2 = 8'h9d,
  parameter logic [7:0] FLASH_TRIM3 = 8'h6b
) (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output logic      [7:0] o_addr = 8'h00,
  output logic            o_wr = 1'b0,
  output logic            o_rd = 1'b0,
  output logic      [7:0] o_wdata = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    if (a != atrb_pkg::TEST_OFS) begin
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(negedge i_sys_clk);
      o_wr <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_sys_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(negedge i_sys_clk);
    o_rd <= 1'b0;
    d = i_rdata;
    v = i_rvalid;
  endtask
  // Factory bytes go in once, after the first reset only
  task automatic copy_trims();
    wr(atrb_pkg::TRIM1_OFS, FLASH_TRIM1);
    wr(atrb_pkg::TRIM2_OFS, FLASH_TRIM2);
    wr(atrb_pkg::TRIM3_OFS, FLASH_TRIM3);
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
/* Self-checking bench of the trim register bank.
   Assumes the bank's two-edge trim latency and one-cycle read answer. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic i_sys_clk, i_rst_n, sel, raw, wr, rd, rv, shut, wide, v;
  logic [7:0] adr, wd, rdat, d, t1, t2, t3;
  logic [3:0] rtrim;
  logic [2:0] b12, b34, hs23, hs1;
  int bad_count, checks_done, n;
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  atrb_mcu_model mcu (.i_sys_clk(i_sys_clk), .i_rdata(rdat), .i_rvalid(rv), .o_addr(adr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wd));
  atrb_bank dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(adr), .i_wr(wr),
    .i_rd(rd), .i_wdata(wd), .i_current_sense_select(sel), .i_overcurrent_raw(raw),
    .o_rdata(rdat), .o_rvalid(rv), .o_reference_current_trim(rtrim), .o_bridge12_trim(b12),
    .o_bridge34_trim(b34), .o_bridge_trim_wide(wide), .o_highside23_trim(hs23),
    .o_highside1_trim(hs1), .o_overcurrent_shutdown(shut));
  // Reserved three-bit code means no adjustment
  function automatic logic [31:0] f3(input logic [2:0] c);
    return (c == 3'h4) ? 0 : c;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    {t1, t2, t3} = '0;
  endtask
  task automatic chk_all();
    mcu.rd(8'h0f, d, v);
    chk(v, 1);
    chk(d, {t1[7:6], 6'h0});
    mcu.rd(8'h10, d, v);
    chk(d, 0);
    mcu.rd(8'h11, d, v);
    chk(d, 0);
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      repeat (2) @(negedge i_sys_clk);
      chk(rtrim, (t1[3:0] > 4'h8) ? 0 : t1[3:0]);
      chk(b12, s ? f3(t2[2:0]) : t2[7:6]);
      chk(b34, s ? f3(t2[5:3]) : t3[7:6]);
      chk(hs23, f3(t3[5:3]));
      chk(hs1, f3(t3[2:0]));
      chk(wide, s);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    mcu.wr(8'h0f, a);
    mcu.wr(8'h10, b);
    mcu.wr(8'h11, c);
    {t1, t2, t3} = {a, b, c};
    chk_all();
  endtask
  task automatic oc(input logic [1:0] dl, input int nc);
    put({dl, 6'h0}, t2, t3);
    raw = 1'b1;
    n = 0;
    while (shut !== 1'b1 && n < 30000) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(n, nc);
    if (n >= 30000) report_and_stop();
    raw = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk(shut, 0);
  endtask
  initial begin
    {i_rst_n, sel, raw, bad_count, checks_done} = '0;
    n = $urandom(32'hc4662226);
    do_reset();
    chk_all();
    mcu.copy_trims();
    {t1, t2, t3} = {mcu.FLASH_TRIM1, mcu.FLASH_TRIM2, mcu.FLASH_TRIM3};
    chk_all();
    $display("test reset and factory copy done");
    // Sweep covers every reference code and every three-bit code
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      put({d[7:4], i[3:0]}, {i[1:0], i[2:0], i[3:1]}, {d[1:0], i[3:1], i[2:0]});
    end
    mcu.rd(8'h0e, d, v);
    chk(d, 0);
    mcu.rd(8'h12, d, v);
    chk(d, 0);
    $display("test code sweep done");
    oc(2'h3, atrb_pkg::DLY3_CYC);
    oc(2'h2, atrb_pkg::DLY2_CYC);
    // Slow settings only checked to outlast 234us; full waits would overrun the run budget
    for (int k = 0; k < 2; k++) begin
      put({k[1:0], 6'h0}, t2, t3);
      raw = 1'b1;
      repeat (atrb_pkg::DLY2_CYC) @(negedge i_sys_clk);
      chk(shut, 0);
      raw = 1'b0;
      repeat (2) @(negedge i_sys_clk);
      chk(shut, 0);
    end
    $display("test overcurrent filter done");
    put(8'hff, 8'hff, 8'hff);
    do_reset();
    chk_all();
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
